/* sbl_pkg.sv */
// Purpose: constants for the serial boot loader command interpreter
// Assumes: byte-wide receive and transmit paths on one clock
// Notes: none
package sbl_pkg;
  localparam logic [7:0] MODE_UART = 8'h86;
  localparam logic [7:0] MODE_IO = 8'h30;
  localparam logic [7:0] CMD_RAM = 8'h10;
  localparam logic [7:0] CMD_SUM = 8'h20;
  localparam logic [7:0] ACK_RAM = 8'h10;
  localparam logic [7:0] NAK_CODE = 8'h01;
  localparam logic [7:0] ERR_CODE = 8'h08;
  localparam int PW_BYTES = 12;
  localparam int HDR_BYTES = 6;
  localparam logic [3:0] PW_LAST = 4'hb;
  localparam logic [3:0] HDR_LAST = 4'h5;
  localparam logic [3:0] HDR_ADDR_LAST = 4'h3;
  localparam logic [3:0] IDX_RST = 4'h0;
  localparam logic [7:0] SUM_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  typedef enum logic [3:0] {
    SBL_MODE, SBL_CMD, SBL_PW, SBL_PWSUM, SBL_HDR, SBL_HDRSUM,
    SBL_DATA, SBL_DSUM, SBL_SEND, SBL_FSH, SBL_FSL, SBL_FSC,
    SBL_JUMP, SBL_RUN, SBL_ABORT
  } sbl_state_e;
endpackage : sbl_pkg

/* sbl_stream_if.sv */
// Purpose: byte stream with valid and ready between loader modules
// Assumes: one clock
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface sbl_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : sbl_stream_if
`default_nettype wire

/* sbl_buf2.sv */
// Purpose: two-entry buffer on the transmit byte path
// Assumes: consumer may stall at any time
// Notes: ready on either side is honest full or empty
`timescale 1ns/1ps
`default_nettype none
module sbl_buf2 #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // fill side
  sbl_stream_if.snk in_s,
  // drain side
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic [1:0] cnt;
  } sbl_buf_s;
  sbl_buf_s r, n;
  logic push, pop;
  assign in_s.ready = (r.cnt != 2'h2);
  assign out_valid_o = (r.cnt != 2'h0);
  assign out_data_o = r.mem[0];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_valid_o && out_ready_i;
  always_comb begin
    n = r;
    if (pop) begin
      n.mem[0] = r.mem[1];
    end
    if (push) begin
      if (r.cnt == 2'h0 || (r.cnt == 2'h1 && pop)) begin
        n.mem[0] = in_s.data;
      end else begin
        n.mem[1] = in_s.data;
      end
    end
    n.cnt = r.cnt + {1'b0, push} - {1'b0, pop};
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule : sbl_buf2
`default_nettype wire

/* sbl_core.sv */
// Purpose: serial boot loader command interpreter, byte level
// Assumes: receiver and transmitter byte logic sit on the same clock
// Notes: negative and error answers carry zero in the upper nibble
//
// Behaviour
// - good checksum answered with 0x10
// - negative answer has low nibble 1
// - receive error answered with low nibble 8
// - payload streamed then checked by its checksum
// - payload checksum answered with same codes
// - good payload starts execution at load address
// - after negative answer wait for command
// - io mode errors give no negative answer
// - echo the mode byte
// - uart baud failure aborts session
// - flash-sum command echoed as 0x20
// - send sum high, low, then checksum
// - after sum checksum wait for command
// - password and its checksum precede address
`timescale 1ns/1ps
`default_nettype none
module sbl_core #(
  parameter int BUF_W = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // received bytes
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_err_i,
  output logic rx_ready_o,
  input wire logic baud_ok_i,
  // transmitted bytes
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  // device data
  input wire logic [95:0] password_i,
  input wire logic [15:0] flash_sum_i,
  // RAM load and hand-off
  output logic ram_we_o,
  output logic [31:0] ram_addr_o,
  output logic [7:0] ram_data_o,
  output logic jump_o,
  output logic [31:0] jump_addr_o,
  output logic io_mode_o,
  output logic abort_o
);
  typedef struct packed {
    sbl_pkg::sbl_state_e st;
    sbl_pkg::sbl_state_e ret;
    logic [7:0] txb;
    logic [7:0] sum;
    logic [3:0] idx;
    logic pw_ok;
    logic io;
    logic [31:0] addr;
    logic [15:0] len;
    logic [15:0] cnt;
    logic we;
    logic [31:0] waddr;
    logic [7:0] wdata;
    logic jump;
  } sbl_core_s;
  sbl_core_s r, n;
  sbl_stream_if #(.W(BUF_W)) tx_s ();
  logic rx_take;
  logic [7:0] sum_nxt;
  logic [7:0] pw_byte;

  sbl_buf2 #(.W(BUF_W)) u_txbuf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_s(tx_s.snk),
    .out_valid_o(tx_valid_o),
    .out_data_o(tx_data_o),
    .out_ready_i(tx_ready_i)
  );

  // no byte is taken while an answer is pending
  assign rx_ready_o = (r.st != sbl_pkg::SBL_SEND) &&
                      (r.st != sbl_pkg::SBL_FSH) &&
                      (r.st != sbl_pkg::SBL_FSL) &&
                      (r.st != sbl_pkg::SBL_FSC) &&
                      (r.st != sbl_pkg::SBL_JUMP) &&
                      (r.st != sbl_pkg::SBL_RUN) &&
                      (r.st != sbl_pkg::SBL_ABORT);
  assign rx_take = rx_valid_i && rx_ready_o;
  assign tx_s.valid = (r.st == sbl_pkg::SBL_SEND);
  assign tx_s.data = r.txb;
  assign sum_nxt = r.sum + rx_data_i;
  assign pw_byte = password_i[8'(95 - 8 * int'(r.idx)) -: 8];

  assign ram_we_o = r.we;
  assign ram_addr_o = r.waddr;
  assign ram_data_o = r.wdata;
  assign jump_o = r.jump;
  assign jump_addr_o = r.addr;
  assign io_mode_o = r.io;
  assign abort_o = (r.st == sbl_pkg::SBL_ABORT);

  always_comb begin
    n = r;
    n.we = 1'b0;
    n.jump = 1'b0;
    if (rx_take && rx_err_i && r.st != sbl_pkg::SBL_MODE) begin
      if (!r.io) begin
        n.txb = sbl_pkg::ERR_CODE;
        n.ret = sbl_pkg::SBL_CMD;
        n.st = sbl_pkg::SBL_SEND;
      end else begin
        n.st = sbl_pkg::SBL_CMD;
      end
    end else begin
      case (r.st)
        sbl_pkg::SBL_MODE: begin
          if (rx_take) begin
            if (rx_data_i == sbl_pkg::MODE_UART && baud_ok_i &&
                !rx_err_i) begin
              n.io = 1'b0;
              n.txb = sbl_pkg::MODE_UART;
              n.ret = sbl_pkg::SBL_CMD;
              n.st = sbl_pkg::SBL_SEND;
            end else if (rx_data_i == sbl_pkg::MODE_IO && !rx_err_i) begin
              n.io = 1'b1;
              n.txb = sbl_pkg::MODE_IO;
              n.ret = sbl_pkg::SBL_CMD;
              n.st = sbl_pkg::SBL_SEND;
            end else begin
              n.st = sbl_pkg::SBL_ABORT;
            end
          end
        end
        sbl_pkg::SBL_CMD: begin
          if (rx_take) begin
            n.sum = sbl_pkg::SUM_RST;
            n.idx = sbl_pkg::IDX_RST;
            n.pw_ok = 1'b1;
            n.st = sbl_pkg::SBL_SEND;
            if (rx_data_i == sbl_pkg::CMD_RAM) begin
              n.txb = sbl_pkg::CMD_RAM;
              n.ret = sbl_pkg::SBL_PW;
            end else if (rx_data_i == sbl_pkg::CMD_SUM) begin
              n.txb = sbl_pkg::CMD_SUM;
              n.ret = sbl_pkg::SBL_FSH;
            end else begin
              n.txb = sbl_pkg::NAK_CODE;
              n.ret = sbl_pkg::SBL_CMD;
            end
          end
        end
        sbl_pkg::SBL_PW: begin
          if (rx_take) begin
            n.sum = sum_nxt;
            if (rx_data_i != pw_byte) begin
              n.pw_ok = 1'b0;
            end
            n.idx = r.idx + 4'h1;
            if (r.idx == sbl_pkg::PW_LAST) begin
              n.st = sbl_pkg::SBL_PWSUM;
            end
          end
        end
        sbl_pkg::SBL_HDR: begin
          if (rx_take) begin
            n.sum = sum_nxt;
            if (r.idx <= sbl_pkg::HDR_ADDR_LAST) begin
              n.addr = {r.addr[23:0], rx_data_i};
            end else begin
              n.len = {r.len[7:0], rx_data_i};
            end
            n.idx = r.idx + 4'h1;
            if (r.idx == sbl_pkg::HDR_LAST) begin
              n.st = sbl_pkg::SBL_HDRSUM;
            end
          end
        end
        sbl_pkg::SBL_DATA: begin
          if (rx_take) begin
            n.sum = sum_nxt;
            n.we = 1'b1;
            n.waddr = r.addr + 32'(r.cnt);
            n.wdata = rx_data_i;
            n.cnt = r.cnt + 16'h0001;
            if (r.cnt + 16'h0001 == r.len) begin
              n.st = sbl_pkg::SBL_DSUM;
            end
          end
        end
        sbl_pkg::SBL_PWSUM, sbl_pkg::SBL_HDRSUM, sbl_pkg::SBL_DSUM: begin
          if (rx_take) begin
            n.st = sbl_pkg::SBL_SEND;
            n.sum = sbl_pkg::SUM_RST;
            n.idx = sbl_pkg::IDX_RST;
            n.cnt = sbl_pkg::CNT_RST;
            if (sum_nxt != sbl_pkg::SUM_RST ||
                (r.st == sbl_pkg::SBL_PWSUM && !r.pw_ok)) begin
              n.txb = sbl_pkg::NAK_CODE;
              n.ret = sbl_pkg::SBL_CMD;
            end else begin
              n.txb = sbl_pkg::ACK_RAM;
              if (r.st == sbl_pkg::SBL_PWSUM) begin
                n.ret = sbl_pkg::SBL_HDR;
              end else if (r.st == sbl_pkg::SBL_HDRSUM) begin
                n.ret = (r.len == sbl_pkg::CNT_RST) ? sbl_pkg::SBL_DSUM :
                        sbl_pkg::SBL_DATA;
              end else begin
                n.ret = sbl_pkg::SBL_JUMP;
              end
            end
          end
        end
        sbl_pkg::SBL_SEND: begin
          if (tx_s.ready) begin
            n.st = r.ret;
          end
        end
        sbl_pkg::SBL_FSH: begin
          n.txb = flash_sum_i[15:8];
          n.ret = sbl_pkg::SBL_FSL;
          n.st = sbl_pkg::SBL_SEND;
        end
        sbl_pkg::SBL_FSL: begin
          n.txb = flash_sum_i[7:0];
          n.ret = sbl_pkg::SBL_FSC;
          n.st = sbl_pkg::SBL_SEND;
        end
        sbl_pkg::SBL_FSC: begin
          n.txb = 8'h00 - (flash_sum_i[15:8] + flash_sum_i[7:0]);
          n.ret = sbl_pkg::SBL_CMD;
          n.st = sbl_pkg::SBL_SEND;
        end
        sbl_pkg::SBL_JUMP: begin
          n.jump = 1'b1;
          n.st = sbl_pkg::SBL_RUN;
        end
        sbl_pkg::SBL_RUN, sbl_pkg::SBL_ABORT: begin
          n.st = r.st;
        end
        default: begin
          n.st = sbl_pkg::SBL_ABORT;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.st <= sbl_pkg::SBL_MODE;
      r.ret <= sbl_pkg::SBL_MODE;
    end else begin
      r <= n;
    end
  end
endmodule : sbl_core
`default_nettype wire

/* sbl_core_asserts.sv */
// Purpose: port checks for the boot loader interpreter
// Assumes: one clock, synchronous reset
// Notes: first_r marks the mode byte slot
`timescale 1ns/1ps
`default_nettype none
module sbl_core_asserts (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // receive side
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_err_i,
  input wire logic rx_ready_o,
  input wire logic baud_ok_i,
  // transmit side
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  // load and status
  input wire logic ram_we_o,
  input wire logic [7:0] ram_data_o,
  input wire logic jump_o,
  input wire logic io_mode_o,
  input wire logic abort_o
);
  logic tk;
  logic first_r;
  assign tk = rx_valid_i && rx_ready_o;
  always_ff @(posedge clk_i) first_r <= rst_i || (first_r && !tk);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence echo_s(logic [7:0] b);
    ##2 tx_valid_o && tx_data_o == b;
  endsequence
  reset_idle_a: assert property ($fell(rst_i) |-> rx_ready_o && !tx_valid_o)
    else $error("not idle after reset");
  tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("answer byte dropped");
  ram_write_a: assert property (ram_we_o |-> $past(tk) && ram_data_o == $past(rx_data_i))
    else $error("bad payload write");
  jump_pulse_a: assert property (jump_o |=> !jump_o && !rx_ready_o)
    else $error("jump not a pulse");
  abort_hold_a: assert property (abort_o |=> abort_o && !rx_ready_o)
    else $error("abort not held");
  io_echo_a: assert property (first_r && tk && !rx_err_i && rx_data_i == sbl_pkg::MODE_IO
    |-> echo_s(sbl_pkg::MODE_IO) ##0 io_mode_o)
    else $error("io mode not echoed");
  uart_echo_a: assert property (first_r && tk && !rx_err_i && baud_ok_i
    && rx_data_i == sbl_pkg::MODE_UART |-> echo_s(sbl_pkg::MODE_UART))
    else $error("uart mode not echoed");
  baud_abort_a: assert property (first_r && tk && rx_data_i == sbl_pkg::MODE_UART
    && !baud_ok_i |-> ##[1:3] abort_o)
    else $error("no abort on baud fail");
  err_reply_a: assert property (!first_r && tk && rx_err_i && !io_mode_o
    |-> ##[2:40] tx_valid_o && tx_data_o == sbl_pkg::ERR_CODE)
    else $error("no error reply");
  io_quiet_a: assert property (!first_r && tk && rx_err_i && io_mode_o && !tx_valid_o
    |=> !tx_valid_o [*4])
    else $error("reply after io error");
endmodule : sbl_core_asserts
`default_nettype wire

/* sbl_host.sv */
// Purpose: model of the serial programming controller
// Assumes: same clock as the interpreter
// Notes: slow stalls the answer path every other cycle
`timescale 1ns/1ps
`default_nettype none
module sbl_host (
  // clock
  input wire logic clk_i,
  // bytes to the device
  output var logic rx_valid_o,
  output var logic [7:0] rx_data_o,
  output var logic rx_err_o,
  output var logic baud_ok_o,
  input wire logic rx_ready_i,
  // bytes from the device
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output var logic tx_ready_o
);
  logic [7:0] q[$];
  logic slow;
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    rx_err_o = 1'b0;
    baud_ok_o = 1'b1;
    tx_ready_o = 1'b1;
    slow = 1'b0;
  end
  // one byte held until taken, then the inverse shown
  task send(input logic [7:0] b, input logic e);
    @(posedge clk_i);
    #1;
    rx_valid_o = 1'b1;
    rx_data_o = b;
    rx_err_o = e;
    do @(posedge clk_i); while (!rx_ready_i);
    #1;
    rx_valid_o = 1'b0;
    rx_data_o = ~b;
    rx_err_o = 1'b0;
  endtask : send
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o) q.push_back(tx_data_i);
    #1;
    tx_ready_o = !slow || !tx_ready_o;
  end
endmodule : sbl_host
`default_nettype wire

/* sbl_core_bench.sv */
// Purpose: self-checking bench for the boot loader interpreter
// Assumes: host model on the same clock
// Notes: password and flash sum are fixed bench values
`timescale 1ns/1ps
`default_nettype none
module sbl_core_bench;
  localparam logic [95:0] PW = 96'h0123_4567_89ab_cdef_1357_9bdf;
  localparam logic [15:0] FSUM = 16'h12f3;
  logic clk_i, rst_i, rx_valid, rx_err, baud_ok, rx_ready;
  logic tx_valid, tx_ready, ram_we, jump, io_mode, abort;
  logic [7:0] rx_data, tx_data, ram_data, sum;
  logic [31:0] ram_addr, jump_addr, jaddr;
  logic [39:0] wq[$];
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  sbl_core sbl_core_inst (.clk_i(clk_i), .rst_i(rst_i), .rx_valid_i(rx_valid),
    .rx_data_i(rx_data), .rx_err_i(rx_err), .rx_ready_o(rx_ready),
    .baud_ok_i(baud_ok), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
    .tx_ready_i(tx_ready), .password_i(PW), .flash_sum_i(FSUM),
    .ram_we_o(ram_we), .ram_addr_o(ram_addr), .ram_data_o(ram_data),
    .jump_o(jump), .jump_addr_o(jump_addr), .io_mode_o(io_mode),
    .abort_o(abort));
  sbl_host sbl_host_inst (.clk_i(clk_i), .rx_valid_o(rx_valid),
    .rx_data_o(rx_data), .rx_err_o(rx_err), .baud_ok_o(baud_ok),
    .rx_ready_i(rx_ready), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
    .tx_ready_o(tx_ready));
  always @(posedge clk_i) begin
    if (ram_we) wq.push_back({ram_addr, ram_data});
    if (jump) jaddr = jump_addr;
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      close_out();
    end
  end
  task chk(input string what, input logic [39:0] e, input logic [39:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task rx(input logic [7:0] e);
    int k;
    k = 0;
    while (sbl_host_inst.q.size() == 0 && k < 100) begin
      @(posedge clk_i);
      k++;
    end
    chk("tx byte", e, sbl_host_inst.q.size() ? sbl_host_inst.q.pop_front() : 'x);
  endtask : rx
  // n bytes from the top of v, then a sum byte offset by bad
  task seq(input logic [95:0] v, input int n, input logic [7:0] bad);
    sum = 8'h00;
    for (int i = 0; i < n; i++) begin
      sbl_host_inst.send(v[95-8*i -: 8], 1'b0);
      sum = sum + v[95-8*i -: 8];
    end
    sbl_host_inst.send(8'h00 - sum + bad, 1'b0);
  endtask : seq
  task boot(input logic [7:0] m, input logic ok);
    @(posedge clk_i);
    #1;
    rst_i = 1'b1;
    sbl_host_inst.q.delete();
    sbl_host_inst.baud_ok_o = ok;
    repeat (10) @(posedge clk_i);
    #1 rst_i = 1'b0;
    // io mode: first exchange paced slower than the session
    if (m == sbl_pkg::MODE_IO) repeat (15) @(posedge clk_i);
    sbl_host_inst.send(m, 1'b0);
  endtask : boot
  task t_sum;
    boot(sbl_pkg::MODE_UART, 1'b1);
    rx(sbl_pkg::MODE_UART);
    sbl_host_inst.slow = 1'b1;
    for (int i = 0; i < 2; i++) begin
      sbl_host_inst.send(sbl_pkg::CMD_SUM, 1'b0);
      rx(sbl_pkg::CMD_SUM);
      rx(FSUM[15:8]);
      rx(FSUM[7:0]);
      rx(8'h00 - FSUM[15:8] - FSUM[7:0]);
      sbl_host_inst.send(8'h55, 1'b0);
      rx(sbl_pkg::NAK_CODE);
    end
    sbl_host_inst.slow = 1'b0;
    sbl_host_inst.send(sbl_pkg::CMD_SUM, 1'b1);
    rx(sbl_pkg::ERR_CODE);
  endtask : t_sum
  task t_ram;
    boot(sbl_pkg::MODE_IO, 1'b0);
    rx(sbl_pkg::MODE_IO);
    chk("io mode", 1, io_mode);
    sbl_host_inst.send(sbl_pkg::CMD_RAM, 1'b1);
    repeat (8) @(posedge clk_i);
    chk("io silence", 0, sbl_host_inst.q.size());
    for (int i = 0; i < 2; i++) begin
      sbl_host_inst.send(sbl_pkg::CMD_RAM, 1'b0);
      rx(sbl_pkg::CMD_RAM);
      seq(PW, 12, i ? 8'h00 : 8'h01);
      rx(i ? sbl_pkg::ACK_RAM : sbl_pkg::NAK_CODE);
    end
    seq({32'h2000_0400, 16'h0003, 48'h0}, 6, 8'h00);
    rx(sbl_pkg::ACK_RAM);
    seq({24'ha1b2c3, 72'h0}, 3, 8'h00);
    rx(sbl_pkg::ACK_RAM);
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < 3; i++) begin
      chk("ram write", {32'h2000_0400 + 32'(i), 8'(8'ha1 + 8'h11 * i)}, wq.pop_front());
    end
    chk("jump", 32'h2000_0400, jaddr);
  endtask : t_ram
  // zero byte count: payload checksum follows the header at once
  task t_zero;
    boot(sbl_pkg::MODE_IO, 1'b0);
    rx(sbl_pkg::MODE_IO);
    for (int i = 0; i < 2; i++) begin
      sbl_host_inst.send(sbl_pkg::CMD_RAM, 1'b0);
      rx(sbl_pkg::CMD_RAM);
      seq(PW, 12, 8'h00);
      rx(sbl_pkg::ACK_RAM);
      seq({32'h2000_0800, 64'h0}, 6, 8'h00);
      rx(sbl_pkg::ACK_RAM);
      seq(96'h0, 0, i ? 8'h00 : 8'h01);
      rx(i ? sbl_pkg::ACK_RAM : sbl_pkg::NAK_CODE);
    end
    repeat (4) @(posedge clk_i);
    chk("zero writes", 0, wq.size());
    chk("jump", 32'h2000_0800, jaddr);
  endtask : t_zero
  task t_abort;
    boot(sbl_pkg::MODE_UART, 1'b0);
    repeat (4) @(posedge clk_i);
    chk("abort", 1, abort);
  endtask : t_abort
  task close_out;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out
  initial begin
    rst_i = 1'b1;
    t_sum();
    t_ram();
    t_zero();
    t_abort();
    close_out();
  end
endmodule : sbl_core_bench
bind sbl_core sbl_core_asserts sbl_core_asserts_inst (.clk_i(clk_i),
  .rst_i(rst_i), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
  .rx_err_i(rx_err_i), .rx_ready_o(rx_ready_o), .baud_ok_i(baud_ok_i),
  .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i),
  .ram_we_o(ram_we_o), .ram_data_o(ram_data_o), .jump_o(jump_o),
  .io_mode_o(io_mode_o), .abort_o(abort_o));
`default_nettype wire
